// ===== hdl/mscrp_cmd_path.sv
`timescale 1ns/1ps
`default_nettype none
`include "mscrp_map.svh"

// Summary of operation
// (RQ1) Data flag marks command with data phase
// (RQ2) Init bit inserts 80 idle cycles first
// (RQ3) Block mode ends after length times count bytes
// (RQ4) Stream mode runs until stop command
// (RQ5) Direction bit: 0 read, 1 write
// (RQ6) Format selects none, short, long, no-CRC response
// (RQ7) Busy bit waits for card busy release
// (RQ8) Driver bit: 0 open drain, 1 push-pull
// (RQ9) Index in bits 5-0, bit 6 zero
// (RQ10) Frame: start, transmit, index, argument, CRC, end
// (RQ11) Argument halves map to frame bits
// (RQ12) Command write launches the frame
// (RQ13) Software keeps argument stable while sending
// (RQ14) Argument register keeps value after launch
// (RQ15) Each response overwrites response registers
// (RQ16) Eight halves, two per word, even low
// (RQ17) First response byte goes to index register
// (RQ18) Short response bit placement in halves 7-5
// (RQ19) CRC7 over bits 47-8, then end bit
module mscrp_cmd_path
	import mscrp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        card_clk_i,
	input  wire logic [5:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        cmd_i,
	output logic             cmd_o,
	output logic             cmd_oe_n_o,
	input  wire logic        dat0_i,
	input  wire logic        xfer_byte_i,
	output logic             xfer_active_o,
	output logic             xfer_write_o,
	output logic             xfer_stream_o
);

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] be_merge16(input logic [15:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = be_merge({16'h0000, old_v}, new_v, be);
		return r[15:0];
	endfunction

	function automatic logic [6:0] crc7_step(input logic [6:0] c,
		input logic b);
		logic fb;
		fb = c[6] ^ b;
		return {c[5:3], c[2] ^ fb, c[1:0], fb};
	endfunction

	function automatic logic [6:0] crc7_40(input logic [39:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			c = crc7_step(c, d[i]);
		end
		return c;
	endfunction

	// ---------------- System domain ----------------
	logic        ack_q;
	logic [31:0] rdata_q;
	logic [31:0] cmd_q;
	logic [31:0] arg_q;
	logic [15:0] rsp_q [8];
	logic [7:0]  ridx_q;
	logic [15:0] blen_q;
	logic [15:0] bcnt_q;
	logic        busy_q;
	logic        done_q;
	logic        crc_q;
	logic        tmo_q;
	logic        st_tgl_q;
	logic [39:0] snap_q;
	logic [1:0]  snap_fmt_q;
	logic        snap_init_q;
	logic        snap_bsy_q;
	logic        snap_pp_q;
	logic        dn_s1_q;
	logic        dn_s2_q;
	logic        dn_s3_q;
	logic        xfer_q;
	logic        xdir_q;
	logic        xstr_q;
	logic [31:0] xrem_q;
	logic        req;
	logic        wr_acc;
	logic        launch;
	logic        done_evt;
	logic [31:0] cmd_new;
	logic [31:0] stat_w;
	logic [31:0] rd_mux;

	// Link-domain results read by the system side once done is seen
	logic [135:0] rx_q;
	logic         l_crc_q;
	logic         l_tmo_q;
	logic         dn_tgl_q;

	// One wait state: request taken at the edge where ack_q is high
	assign req               = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_q;
	assign avs_readdata_o    = rdata_q;
	assign wr_acc            = avs_write_i & ack_q;
	assign cmd_new = be_merge(cmd_q, avs_writedata_i, avs_byteenable_i)
		& `MSCRP_CMD_MASK;
	// Command writes while a command is in flight are dropped to keep the
	// snapshot coherent with what the link is shifting
	assign launch   = wr_acc & (avs_address_i == `MSCRP_OFS_CMD) & ~busy_q;
	assign done_evt = dn_s2_q ^ dn_s3_q;

	assign xfer_active_o = xfer_q;
	assign xfer_write_o  = xdir_q;
	assign xfer_stream_o = xstr_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_comb begin
		stat_w = `MSCRP_RST_WORD;
		stat_w[`MSCRP_S_BUSY] = busy_q;
		stat_w[`MSCRP_S_DONE] = done_q;
		stat_w[`MSCRP_S_CRC]  = crc_q;
		stat_w[`MSCRP_S_TMO]  = tmo_q;
		stat_w[`MSCRP_S_XFER] = xfer_q;
		unique case (avs_address_i)
			`MSCRP_OFS_CMD:   rd_mux = cmd_q; // RQ9
			`MSCRP_OFS_ARG:   rd_mux = arg_q;
			`MSCRP_OFS_RSP01: rd_mux = {rsp_q[1], rsp_q[0]}; // RQ16
			`MSCRP_OFS_RSP23: rd_mux = {rsp_q[3], rsp_q[2]};
			`MSCRP_OFS_RSP45: rd_mux = {rsp_q[5], rsp_q[4]};
			`MSCRP_OFS_RSP67: rd_mux = {rsp_q[7], rsp_q[6]};
			`MSCRP_OFS_RIDX:  rd_mux = {24'h000000, ridx_q};
			`MSCRP_OFS_STAT:  rd_mux = stat_w;
			`MSCRP_OFS_BLEN:  rd_mux = {16'h0000, blen_q};
			`MSCRP_OFS_BCNT:  rd_mux = {16'h0000, bcnt_q};
			default:          rd_mux = `MSCRP_RST_WORD;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= `MSCRP_RST_WORD;
		end else if (avs_read_i & ~ack_q) begin
			rdata_q <= rd_mux;
		end
	end

	// Command, argument and block settings
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_q  <= `MSCRP_RST_WORD;
			arg_q  <= `MSCRP_RST_WORD;
			blen_q <= `MSCRP_RST_HALF;
			bcnt_q <= `MSCRP_RST_HALF;
		end else if (wr_acc) begin
			if (launch) begin
				cmd_q <= cmd_new; // RQ12
			end
			if (avs_address_i == `MSCRP_OFS_ARG) begin
				arg_q <= be_merge(arg_q, avs_writedata_i,
					avs_byteenable_i); // RQ14
			end
			if (avs_address_i == `MSCRP_OFS_BLEN) begin
				blen_q <= be_merge16(blen_q, avs_writedata_i,
					avs_byteenable_i);
			end
			if (avs_address_i == `MSCRP_OFS_BCNT) begin
				bcnt_q <= be_merge16(bcnt_q, avs_writedata_i,
					avs_byteenable_i);
			end
		end
	end

	// Launch snapshot and start toggle toward the link
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			snap_q      <= 40'h0000000000;
			snap_fmt_q  <= FMT_NONE;
			snap_init_q <= 1'b0;
			snap_bsy_q  <= 1'b0;
			snap_pp_q   <= 1'b0;
			st_tgl_q    <= 1'b0;
			busy_q      <= 1'b0;
		end else if (launch) begin
			snap_q <= {2'b01, cmd_new[`MSCRP_B_IDX_HI:0],
				arg_q[31:16], arg_q[15:0]}; // RQ10 RQ11
			snap_fmt_q  <= cmd_new[`MSCRP_B_FMT_HI:`MSCRP_B_FMT_LO]; // RQ6
			snap_init_q <= cmd_new[`MSCRP_B_INIT]; // RQ2
			snap_bsy_q  <= cmd_new[`MSCRP_B_BUSY]; // RQ7
			snap_pp_q   <= cmd_new[`MSCRP_B_PP]; // RQ8
			st_tgl_q    <= ~st_tgl_q;
			busy_q      <= 1'b1;
		end else if (done_evt) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dn_s1_q <= 1'b0;
			dn_s2_q <= 1'b0;
			dn_s3_q <= 1'b0;
		end else begin
			dn_s1_q <= dn_tgl_q;
			dn_s2_q <= dn_s1_q;
			dn_s3_q <= dn_s2_q;
		end
	end

	// Response registers; a hardware update beats a same-cycle write
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 8; i++) begin
				rsp_q[i] <= `MSCRP_RST_HALF;
			end
			ridx_q <= 8'h00;
		end else if (done_evt && !l_tmo_q && snap_fmt_q != FMT_NONE) begin
			if (snap_fmt_q == FMT_LONG) begin
				ridx_q <= rx_q[135:128]; // RQ17
				for (int i = 0; i < 8; i++) begin
					rsp_q[i] <= rx_q[i*16 +: 16]; // RQ15
				end
			end else begin
				ridx_q   <= rx_q[47:40]; // RQ17
				rsp_q[7] <= rx_q[39:24]; // RQ18
				rsp_q[6] <= rx_q[23:8];
				rsp_q[5] <= {8'h00, rx_q[7:0]};
			end
		end else if (wr_acc) begin
			for (int i = 0; i < 4; i++) begin
				if (avs_address_i == `MSCRP_OFS_RSP01 + 6'(i * 4)) begin
					{rsp_q[2*i+1], rsp_q[2*i]} <= be_merge(
						{rsp_q[2*i+1], rsp_q[2*i]}, avs_writedata_i,
						avs_byteenable_i);
				end
			end
			if (avs_address_i == `MSCRP_OFS_RIDX) begin
				ridx_q <= avs_byteenable_i[0] ? avs_writedata_i[7:0]
					: ridx_q;
			end
		end
	end

	// Sticky status, cleared by writing one; the event wins
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			done_q <= 1'b0;
			crc_q  <= 1'b0;
			tmo_q  <= 1'b0;
		end else begin
			if (done_evt) begin
				done_q <= 1'b1;
				crc_q  <= crc_q | l_crc_q;
				tmo_q  <= tmo_q | l_tmo_q;
			end else if (wr_acc && avs_address_i == `MSCRP_OFS_STAT
				&& avs_byteenable_i[0]) begin
				done_q <= done_q & ~avs_writedata_i[`MSCRP_S_DONE];
				crc_q  <= crc_q & ~avs_writedata_i[`MSCRP_S_CRC];
				tmo_q  <= tmo_q & ~avs_writedata_i[`MSCRP_S_TMO];
			end
		end
	end

	// Data-phase bookkeeping handed to the data path
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xfer_q <= 1'b0;
			xdir_q <= 1'b0;
			xstr_q <= 1'b0;
			xrem_q <= `MSCRP_RST_WORD;
		end else if (launch && cmd_new[`MSCRP_B_DATA]) begin
			xfer_q <= 1'b1; // RQ1
			xdir_q <= cmd_new[`MSCRP_B_DIR]; // RQ5
			xstr_q <= cmd_new[`MSCRP_B_STREAM];
			xrem_q <= 32'(blen_q) * 32'(bcnt_q);
		end else if (xfer_q && xstr_q) begin
			if (launch &&
				cmd_new[`MSCRP_B_IDX_HI:0] == `MSCRP_IDX_STOP) begin
				xfer_q <= 1'b0; // RQ4
			end
		end else if (xfer_q) begin
			if (xrem_q == `MSCRP_RST_WORD) begin
				xfer_q <= 1'b0; // RQ3
			end else if (xfer_byte_i) begin
				xrem_q <= xrem_q - 32'd1;
			end
		end
	end

	// ---------------- Link domain ----------------
	mscrp_lstate_t lst_q;
	logic          st_s1_q;
	logic          st_s2_q;
	logic          st_s3_q;
	logic          ci_s1_q;
	logic          ci_s2_q;
	logic          d0_s1_q;
	logic          d0_s2_q;
	logic [47:0]   tx_q;
	logic [7:0]    cnt_q;
	logic [6:0]    wcnt_q;
	logic [6:0]    rcrc_q;
	logic [7:0]    rlen;
	logic [7:0]    rpos;
	logic          in_win;
	logic          start_evt;
	logic [39:0]   fr40;

	assign start_evt = st_s2_q ^ st_s3_q;
	assign fr40      = snap_q;
	assign rlen = (snap_fmt_q == FMT_LONG) ? `MSCRP_LEN_LONG
		: `MSCRP_LEN_SHORT;
	assign rpos   = rlen - 8'd1 - cnt_q;
	assign in_win = (rpos >= `MSCRP_CRC_BOT) &&
		((snap_fmt_q != FMT_LONG) || (rpos <= `MSCRP_CRC_TOP_L));

	assign cmd_o = tx_q[47];
	// Open drain releases the line for ones; idle is released too
	assign cmd_oe_n_o = ~((lst_q == L_TX) & (snap_pp_q | ~tx_q[47])); // RQ8

	always_ff @(posedge card_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_s1_q <= 1'b0;
			st_s2_q <= 1'b0;
			st_s3_q <= 1'b0;
			ci_s1_q <= 1'b1;
			ci_s2_q <= 1'b1;
			d0_s1_q <= 1'b1;
			d0_s2_q <= 1'b1;
		end else begin
			st_s1_q <= st_tgl_q;
			st_s2_q <= st_s1_q;
			st_s3_q <= st_s2_q;
			ci_s1_q <= cmd_i;
			ci_s2_q <= ci_s1_q;
			d0_s1_q <= dat0_i;
			d0_s2_q <= d0_s1_q;
		end
	end

	always_ff @(posedge card_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lst_q    <= L_IDLE;
			tx_q     <= 48'hFFFFFFFFFFFF;
			cnt_q    <= 8'h00;
			wcnt_q   <= 7'h00;
			rcrc_q   <= 7'h00;
			rx_q     <= 136'h0;
			l_crc_q  <= 1'b0;
			l_tmo_q  <= 1'b0;
			dn_tgl_q <= 1'b0;
		end else begin
			unique case (lst_q)
				L_IDLE: begin
					if (start_evt) begin
						tx_q    <= {fr40, crc7_40(fr40), 1'b1}; // RQ19
						cnt_q   <= 8'h00;
						wcnt_q  <= 7'h00;
						l_crc_q <= 1'b0;
						l_tmo_q <= 1'b0;
						lst_q   <= snap_init_q ? L_INIT : L_TX; // RQ2
					end
				end
				L_INIT: begin
					wcnt_q <= wcnt_q + 7'd1;
					if (wcnt_q == `MSCRP_INIT_CYC - 7'd1) begin
						wcnt_q <= 7'h00;
						lst_q  <= L_TX; // RQ2
					end
				end
				L_TX: begin
					tx_q  <= {tx_q[46:0], 1'b1}; // RQ10
					cnt_q <= cnt_q + 8'd1;
					if (cnt_q == `MSCRP_LEN_SHORT - 8'd1) begin
						cnt_q  <= 8'h00;
						rcrc_q <= 7'h00;
						if (snap_fmt_q == FMT_NONE) begin
							lst_q    <= L_IDLE; // RQ6
							dn_tgl_q <= ~dn_tgl_q;
						end else begin
							lst_q <= L_WAIT;
						end
					end
				end
				L_WAIT: begin
					wcnt_q <= wcnt_q + 7'd1;
					// The synchroniser still echoes our last two frame bits
					if (!ci_s2_q && wcnt_q >= 7'd2) begin
						rx_q  <= {135'h0, 1'b0};
						cnt_q <= 8'd1;
						if (in_win) begin
							rcrc_q <= crc7_step(7'h00, 1'b0);
						end
						lst_q <= L_RX;
					end else if (wcnt_q == `MSCRP_RSP_TMO - 7'd1) begin
						l_tmo_q  <= 1'b1;
						lst_q    <= L_IDLE;
						dn_tgl_q <= ~dn_tgl_q;
					end
				end
				L_RX: begin
					rx_q  <= {rx_q[134:0], ci_s2_q};
					cnt_q <= cnt_q + 8'd1;
					if (in_win) begin
						rcrc_q <= crc7_step(rcrc_q, ci_s2_q);
					end
					if (cnt_q == rlen - 8'd1) begin
						l_crc_q <= (snap_fmt_q != FMT_NOCRC) &&
							(rcrc_q != rx_q[6:0]); // RQ6
						if (snap_bsy_q) begin
							lst_q <= L_BUSY; // RQ7
						end else begin
							lst_q    <= L_IDLE;
							dn_tgl_q <= ~dn_tgl_q;
						end
					end
				end
				L_BUSY: begin
					if (d0_s2_q) begin
						lst_q    <= L_IDLE; // RQ7
						dn_tgl_q <= ~dn_tgl_q;
					end
				end
				default: lst_q <= L_IDLE;
			endcase
		end
	end

	// ---------------- Checks ----------------
	a_cmd_launch: assert property (@(posedge clk_i) disable iff (!rstn_i)
		launch |=> busy_q && st_tgl_q != $past(st_tgl_q)) // RQ12
		else $error("command write did not launch");
	a_arg_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!(wr_acc && avs_address_i == `MSCRP_OFS_ARG) |=> $stable(arg_q))
		// RQ14
		else $error("argument changed without a write");
	a_rsv_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(avs_read_i && ack_q) |-> cmd_q[6] == 1'b0) // RQ9
		else $error("reserved command bit nonzero");
	a_short_place: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(done_evt && !l_tmo_q && snap_fmt_q == FMT_SHORT)
		|=> rsp_q[7] == $past(rx_q[39:24]) && ridx_q == $past(rx_q[47:40]))
		// RQ18
		else $error("short response misplaced");
	a_block_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(xfer_q && !xstr_q && xrem_q == 32'd0 && !launch) |=> !xfer_q) // RQ3
		else $error("block transfer did not stop");
	a_stream_run: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(xfer_q && xstr_q && !launch) |=> xfer_q) // RQ4
		else $error("stream transfer stopped early");
	a_start_bit: assert property (@(posedge card_clk_i) disable iff (!rstn_i)
		(lst_q == L_TX && cnt_q == 8'd0) |-> !cmd_o && !cmd_oe_n_o) // RQ10
		else $error("start bit not driven low");
	a_end_bit: assert property (@(posedge card_clk_i) disable iff (!rstn_i)
		(lst_q == L_TX && cnt_q == 8'd47) |-> cmd_o) // RQ19
		else $error("end bit not one");
	a_open_drain: assert property (@(posedge card_clk_i) disable iff (!rstn_i)
		(!cmd_oe_n_o && !snap_pp_q) |-> !cmd_o) // RQ8
		else $error("open drain drove a one");
	a_init_len: assert property (@(posedge card_clk_i) disable iff (!rstn_i)
		(lst_q == L_TX && $past(lst_q) == L_INIT)
		|-> $past(wcnt_q) == 7'd79) // RQ2
		else $error("init idle length wrong");

	c_launch: cover property (@(posedge clk_i) disable iff (!rstn_i)
		launch);
	c_rsp: cover property (@(posedge clk_i) disable iff (!rstn_i)
		done_evt && !l_tmo_q);
	c_xfer_end: cover property (@(posedge clk_i) disable iff (!rstn_i)
		$fell(xfer_q));

endmodule

`default_nettype wire

// ===== hdl/mscrp_map.svh
`ifndef MSCRP_MAP_SVH
`define MSCRP_MAP_SVH

// Register byte offsets
`define MSCRP_OFS_CMD      6'h00
`define MSCRP_OFS_ARG      6'h04
`define MSCRP_OFS_RSP01    6'h08
`define MSCRP_OFS_RSP23    6'h0C
`define MSCRP_OFS_RSP45    6'h10
`define MSCRP_OFS_RSP67    6'h14
`define MSCRP_OFS_RIDX     6'h18
`define MSCRP_OFS_STAT     6'h1C
`define MSCRP_OFS_BLEN     6'h20
`define MSCRP_OFS_BCNT     6'h24

// Command word fields
`define MSCRP_CMD_MASK     32'h00007FBF
`define MSCRP_B_INIT       14
`define MSCRP_B_DATA       13
`define MSCRP_B_STREAM     12
`define MSCRP_B_DIR        11
`define MSCRP_B_FMT_HI     10
`define MSCRP_B_FMT_LO     9
`define MSCRP_B_BUSY       8
`define MSCRP_B_PP         7
`define MSCRP_B_IDX_HI     5

// Status fields
`define MSCRP_S_BUSY       0
`define MSCRP_S_DONE       1
`define MSCRP_S_CRC        2
`define MSCRP_S_TMO        3
`define MSCRP_S_XFER       4

// Reset values
`define MSCRP_RST_WORD     32'h00000000
`define MSCRP_RST_HALF     16'h0000

// Frame and timing
`define MSCRP_IDX_STOP     6'h0C
`define MSCRP_INIT_CYC     7'd80
`define MSCRP_RSP_TMO      7'd64
`define MSCRP_LEN_SHORT    8'd48
`define MSCRP_LEN_LONG     8'd136
`define MSCRP_CRC_TOP_L    8'd127
`define MSCRP_CRC_BOT      8'd8

`endif

// ===== hdl/mscrp_pkg.sv
package mscrp_pkg;

	typedef enum logic [2:0] {
		L_IDLE = 3'b000,
		L_INIT = 3'b001,
		L_TX   = 3'b010,
		L_WAIT = 3'b011,
		L_RX   = 3'b100,
		L_BUSY = 3'b101
	} mscrp_lstate_t;

	typedef enum logic [1:0] {
		FMT_NONE  = 2'b00,
		FMT_SHORT = 2'b01,
		FMT_LONG  = 2'b10,
		FMT_NOCRC = 2'b11
	} mscrp_fmt_t;

endpackage

// ===== tb/mscrp_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module mscrp_card_model (
	input  wire logic         card_clk_i,
	input  wire logic         rstn_i,
	input  wire logic         cmd_o_i,
	input  wire logic         cmd_oe_n_i,
	input  wire logic         pp_i,
	input  wire logic [7:0]   resp_len_i,
	input  wire logic [135:0] resp_i,
	input  wire logic [7:0]   busy_cyc_i,
	output logic              cmd_line_o,
	output logic              dat0_o,
	output logic              rx_on_o,
	output logic [47:0]       frame_o,
	output logic [7:0]        frame_cnt_o,
	output logic [7:0]        busy_cnt_o,
	output logic [7:0]        viol_o
);
	logic        card_en;
	logic        card_bit;
	logic [47:0] f;

	// Wired-and with a pull-up, so a released line reads 1
	assign cmd_line_o = (cmd_oe_n_i ? 1'b1 : cmd_o_i) &
		(card_en ? card_bit : 1'b1);

	task automatic chk_drv(input logic b);
		if (cmd_oe_n_i !== (pp_i ? 1'b0 : b)) begin
			viol_o = viol_o + 8'h01;
		end
	endtask

	initial begin
		card_en = 1'b0;
		card_bit = 1'b1;
		dat0_o = 1'b1;
		rx_on_o = 1'b0;
		frame_o = 48'h0;
		f = 48'h0;
		frame_cnt_o = 8'h00;
		busy_cnt_o = 8'h00;
		viol_o = 8'h00;
		forever begin
			@(negedge card_clk_i);
			if (rstn_i === 1'b1 && cmd_line_o === 1'b0) begin
				rx_on_o = 1'b1;
				f[47] = 1'b0;
				chk_drv(1'b0);
				for (int i = 46; i >= 0; i--) begin
					@(negedge card_clk_i);
					f[i] = cmd_line_o;
					chk_drv(f[i]);
				end
				rx_on_o = 1'b0;
				frame_o = f;
				frame_cnt_o = frame_cnt_o + 8'h01;
				if (resp_len_i != 8'h00) begin
					repeat (4) @(negedge card_clk_i);
					card_en = 1'b1;
					for (int i = int'(resp_len_i) - 1; i >= 0; i--) begin
						card_bit = resp_i[i];
						@(negedge card_clk_i);
					end
					card_en = 1'b0;
					if (busy_cyc_i != 8'h00) begin
						dat0_o = 1'b0;
						repeat (busy_cyc_i) @(negedge card_clk_i);
						dat0_o = 1'b1;
						busy_cnt_o = busy_cnt_o + 8'h01;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mscrp_map.svh"
module tb;
	logic         clk_i;
	logic         rstn_i;
	logic         card_clk;
	logic [5:0]   addr;
	logic         rd;
	logic         wr;
	logic [31:0]  wdata;
	logic [3:0]   be;
	logic [31:0]  rdata;
	logic         wreq;
	logic         cmd_o;
	logic         cmd_oe_n;
	logic         cmd_line;
	logic         dat0;
	logic         xbyte;
	logic         xact;
	logic         xwr;
	logic         xstr;
	logic         pp;
	logic [7:0]   resp_len;
	logic [135:0] resp;
	logic [7:0]   busy_cyc;
	logic         rx_on;
	logic [47:0]  frame;
	logic [7:0]   frame_cnt;
	logic [7:0]   busy_cnt;
	logic [7:0]   viol;
	logic [31:0]  lfsr_q;
	logic [15:0]  exp_h [8];
	logic [7:0]   exp_idx;
	logic [31:0]  d;
	logic [31:0]  c;
	int           n_errors;
	int           tests_run;

	mscrp_cmd_path dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
		.card_clk_i(card_clk), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.cmd_i(cmd_line), .cmd_o(cmd_o), .cmd_oe_n_o(cmd_oe_n),
		.dat0_i(dat0), .xfer_byte_i(xbyte), .xfer_active_o(xact),
		.xfer_write_o(xwr), .xfer_stream_o(xstr));

	mscrp_card_model card_u (.card_clk_i(card_clk), .rstn_i(rstn_i),
		.cmd_o_i(cmd_o), .cmd_oe_n_i(cmd_oe_n), .pp_i(pp),
		.resp_len_i(resp_len), .resp_i(resp), .busy_cyc_i(busy_cyc),
		.cmd_line_o(cmd_line), .dat0_o(dat0), .rx_on_o(rx_on),
		.frame_o(frame), .frame_cnt_o(frame_cnt), .busy_cnt_o(busy_cnt),
		.viol_o(viol));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial begin
		card_clk = 1'b0;
		#7;
		forever #15 card_clk = ~card_clk;
	end

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [47:0] e,
			input logic [47:0] g);
		tests_run++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", what, e, g);
			n_errors++;
		end
	endtask

	task automatic hang(input string what);
		$display("Error %s expected done seen timeout", what);
		n_errors++;
		tally_and_finish();
	endtask

	function automatic logic [31:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction

	function automatic logic [6:0] crc7(input logic [135:0] v, input int top);
		logic [6:0] r;
		logic       fb;
		r = 7'h00;
		for (int i = top; i >= 8; i--) begin
			fb = v[i] ^ r[6];
			r = {r[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
		end
		return r;
	endfunction

	// Request held until waitrequest is sampled low at a rising edge
	task automatic bus_wait();
		int n;
		n = 0;
		@(posedge clk_i);
		while (wreq !== 1'b0) begin
			if (n++ > 50) hang("waitrequest");
			@(posedge clk_i);
		end
	endtask

	task automatic bus_wr(input logic [5:0] a, input logic [31:0] v,
			input logic [3:0] b);
		addr <= a;
		wdata <= v;
		be <= b;
		wr <= 1'b1;
		bus_wait();
		wr <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic bus_rd(input logic [5:0] a, output logic [31:0] v);
		addr <= a;
		rd <= 1'b1;
		bus_wait();
		v = rdata;
		rd <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic pulse(input int k);
		repeat (k) begin
			xbyte <= 1'b1;
			@(posedge clk_i);
			xbyte <= 1'b0;
			@(posedge clk_i);
		end
	endtask

	task automatic cmp_regs();
		logic [31:0] v;
		for (int i = 0; i < 4; i++) begin
			bus_rd(6'(8 + 4 * i), v);
			chk("response pair", {16'h0, exp_h[2*i+1], exp_h[2*i]}, 48'(v));
		end
		bus_rd(`MSCRP_OFS_RIDX, v);
		chk("response index", {40'h0, exp_idx}, 48'(v));
	endtask

	task automatic run_cmd(input logic [31:0] cmd, input logic [31:0] arg,
			input int len, input logic [7:0] bsy, input bit poke);
		logic [47:0] f;
		logic [7:0]  fc;
		logic [7:0]  bc;
		logic [31:0] v;
		int          n;
		f = {2'b01, cmd[5:0], arg, 8'h01};
		f[7:1] = crc7({88'h0, f}, 47);
		pp = cmd[7];
		resp_len = 8'(len);
		busy_cyc = bsy;
		resp = {8'h00, rnd(), rnd(), rnd(), rnd()};
		if (len == 48) begin
			resp[135:40] = {88'h0, 2'b00, cmd[5:0]};
			resp[7:0] = {crc7(resp, 47), 1'b1};
		end else begin
			resp[135:128] = 8'h3F;
			resp[7:0] = {crc7(resp, 127), 1'b1};
		end
		if (cmd[10:9] == 2'h3) begin
			resp[3] = ~resp[3];
		end
		fc = frame_cnt;
		bc = busy_cnt;
		bus_wr(`MSCRP_OFS_ARG, arg, 4'hF);
		bus_wr(`MSCRP_OFS_CMD, cmd, 4'hF);
		n = 0;
		while (rx_on !== 1'b1) begin
			if (n++ > 300) hang("frame start");
			@(posedge card_clk);
		end
		@(posedge clk_i);
		chk("start gap", 48'h1, 48'(cmd[14] ? n >= 76 && n <= 88 : n < 12));
		if (poke) begin
			bus_wr(`MSCRP_OFS_CMD, 32'h0000008C, 4'hF);
		end
		n = 0;
		v = 32'h1;
		while (v[0] !== 1'b0) begin
			if (n++ > 400) hang("status busy");
			bus_rd(`MSCRP_OFS_STAT, v);
		end
		chk("frame", f, frame);
		chk("frame count", 48'(fc + 8'h01), 48'(frame_cnt));
		chk("busy release", 48'(bc + (bsy != 0)), 48'(busy_cnt));
		chk("driver mode", 48'h0, 48'(viol));
		if (len == 48) begin
			exp_idx = resp[47:40];
			exp_h[7] = resp[39:24];
			exp_h[6] = resp[23:8];
			exp_h[5] = {8'h00, resp[7:0]};
		end else if (len == 136) begin
			exp_idx = resp[135:128];
			for (int i = 0; i < 8; i++) begin
				exp_h[i] = resp[i*16 +: 16];
			end
		end
		cmp_regs();
		bus_rd(`MSCRP_OFS_ARG, v);
		chk("argument kept", 48'(arg), 48'(v));
		bus_rd(`MSCRP_OFS_CMD, v);
		chk("command word", 48'(cmd & 32'h00007FBF), 48'(v));
	endtask

	initial begin
		rstn_i = 1'b0;
		addr = 6'h00;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 32'h0;
		be = 4'hF;
		xbyte = 1'b0;
		pp = 1'b0;
		resp_len = 8'h00;
		resp = 136'h0;
		busy_cyc = 8'h00;
		lfsr_q = 32'h00014800;
		exp_idx = 8'h00;
		n_errors = 0;
		tests_run = 0;
		for (int i = 0; i < 8; i++) begin
			exp_h[i] = 16'h0000;
		end
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 7; i++) begin
			bus_rd(6'(4 * i), d);
			chk("reset value", 48'h0, 48'(d));
		end
		bus_wr(6'h3C, 32'hFFFFFFFF, 4'hF);
		bus_rd(6'h3C, d);
		chk("unmapped", 48'h0, 48'(d));
		bus_wr(`MSCRP_OFS_ARG, 32'hFFFFFFFF, 4'hF);
		bus_wr(`MSCRP_OFS_ARG, 32'h12345678, 4'h3);
		bus_rd(`MSCRP_OFS_ARG, d);
		chk("byte lanes", 48'hFFFF5678, 48'(d));
		$display("Test registers done");
		// Every response format, with random upper bits and the reserved bit set
		for (int k = 0; k < 4; k++) begin
			c = rnd();
			c = {c[31:15], k == 2, 3'b000, 2'(k), 1'b0, k[0], 1'b1, c[5:0]};
			run_cmd(c, rnd(), k == 0 ? 0 : (k == 2 ? 136 : 48), 8'h00, 0);
			bus_rd(`MSCRP_OFS_STAT, d);
			chk("status errors", 48'h0, 48'(d[3:2]));
			chk("no data phase", 48'h0, 48'(xact));
		end
		$display("Test formats done");
		run_cmd(32'h00000211, rnd(), 0, 8'h00, 0);
		bus_rd(`MSCRP_OFS_STAT, d);
		chk("timeout flag", 48'h1, 48'(d[3]));
		bus_wr(`MSCRP_OFS_STAT, 32'h0000000E, 4'hF);
		run_cmd(32'h00000385, rnd(), 48, 8'd40, 1);
		$display("Test busy done");
		bus_wr(`MSCRP_OFS_BLEN, 32'h4, 4'hF);
		bus_wr(`MSCRP_OFS_BCNT, 32'h2, 4'hF);
		run_cmd(32'h00002811, rnd(), 0, 8'h00, 0);
		chk("block active", 48'h1, 48'(xact));
		chk("block dir", 48'h1, 48'(xwr));
		chk("block mode", 48'h0, 48'(xstr));
		pulse(4 * 2 - 1);
		chk("block not yet done", 48'h1, 48'(xact));
		pulse(1);
		@(posedge clk_i);
		chk("block done", 48'h0, 48'(xact));
		run_cmd(32'h00003012, rnd(), 0, 8'h00, 0);
		chk("stream active", 48'h1, 48'(xact));
		chk("stream dir", 48'h0, 48'(xwr));
		chk("stream mode", 48'h1, 48'(xstr));
		pulse(10);
		chk("stream runs", 48'h1, 48'(xact));
		run_cmd(32'h0000000C, rnd(), 0, 8'h00, 0);
		chk("stream stopped", 48'h0, 48'(xact));
		$display("Test data phase done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
